// >>> sdc_dma.sv
// ============================================================
// Six-channel transfer control with Wishbone slave
//
// Local design decisions: the address map and the Wishbone slave port.
module sdc_dma
    import sdc_pkg::*;
#(
    parameter int AW = 32
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              nrst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Sync sources (asynchronous)
    input  wire logic [NCH-1:0]    sync_irq_i,
    input  wire logic [NCH-1:0]    port_input_ready_i,
    input  wire logic [NCH-1:0]    port_output_ready_i,
    // Memory master (same clock)
    input  wire logic              cpu_req_i,
    input  wire logic              mem_rdy_i,
    input  wire logic [31:0]       mem_rdat_i,
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic      [AW-1:0]     mem_adr_o,
    output logic      [31:0]       mem_wdat_o,
    output logic                   cpu_gnt_o,
    // Interrupt
    output logic                   irq_o
);
    // ============================================================
    // Input synchronisers
    logic [3*NCH-1:0] s1, s2;       // Two-stage sync
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= {sync_irq_i, port_input_ready_i, port_output_ready_i};
            s2 <= s1;
        end
    end
    logic [NCH-1:0] irq_s, ird_s, ord_s;
    assign {irq_s, ird_s, ord_s} = s2;
    logic [NCH-1:0] irq_d;          // Previous sync interrupt level
    // ============================================================
    // State
    logic [31:0]      ctrl   [NCH];  // Control registers
    logic [AW-1:0]    src    [NCH];  // Source addresses
    logic [AW-1:0]    dst    [NCH];  // Destination addresses
    logic [15:0]      cnt    [NCH];  // Element counters
    logic [15:0]      acnt   [NCH];  // Auxiliary counters
    sdc_state_t       st     [NCH];  // Primary half state
    logic [31:0]      dbuf   [NCH];  // Element in flight
    logic [NCH-1:0]   pend;          // Latched sync interrupts
    logic [NCH-1:0]   sie;           // sync_interrupt_enable_reg
    logic [1:0]       prio;          // Priority scheme
    logic [NCH-1:0]   istat, imask;  // Done status, mask
    logic             rot;           // Rotating turn, 1 = CPU last
    logic [2:0]       owner;         // Channel holding the bus
    logic             busy;          // Memory cycle in flight
    logic [31:0]      rdat;
    logic             ack;
    logic [NCH-1:0]   want;          // Channel ready to move
    logic [NCH-1:0]   done_ev;       // Block finished this cycle
    logic [2:0]       pick;
    logic             pick_v, dma_win;
    // Bus decode
    logic             wr, rd_hit;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
    logic [2:0] ch_a;
    assign ch_a = wb_adr_i[7:5];
    // ============================================================
    // Per-channel request: sync gating and halts
    logic [NCH-1:0] rd_need, wr_need;  // Side that waits for a sync event
    for (genvar c = 0; c < NCH; c++) begin : g_want
        logic [1:0] sm;
        logic       rd_ok, wr_ok;
        assign sm = ctrl[c][SYNC_LSB+:2];
        assign rd_need[c] = (sm == SY_SRC) || (sm == SY_BOTH);
        assign wr_need[c] = (sm == SY_DST) || (sm == SY_BOTH && ctrl[c][SAME_PORT_B]);
        // interrupt sync needs a pending interrupt
        assign rd_ok = !rd_need[c] || (sie[c] ? pend[c] : ird_s[c]);
        assign wr_ok = !wr_need[c] || (sie[c] ? pend[c] : ord_s[c]);
        // halt code stops only primary start
        assign want[c] = (ctrl[c][START_LSB+:2] == ST_RUN) &&
                         ((st[c] == SDC_READ && rd_ok) || (st[c] == SDC_WRITE && wr_ok));
    end
    // Block end: last write of a block completes
    always_comb begin
        done_ev = '0;
        if (busy && mem_rdy_i && st[owner] == SDC_WRITE && cnt[owner] == 16'h1) begin
            done_ev[owner] = 1'b1;
        end
    end
    // ============================================================
    // Arbitration: CPU versus channels, channels by fixed order
    always_comb begin
        pick   = 3'h0;
        pick_v = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (want[i]) begin
                pick   = 3'(i);
                pick_v = 1'b1;
            end
        end
        dma_win = pick_v && !busy && (!cpu_req_i || prio == PR_DMA_HIGH ||
                                      (prio == PR_ROTATE && rot));
    end
    // ============================================================
    // Register and transfer state
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl[i] <= CTRL_RESET;
                src[i]  <= '0;
                dst[i]  <= '0;
                cnt[i]  <= '0;
                acnt[i] <= '0;
                st[i]   <= SDC_IDLE;
                dbuf[i] <= '0;
            end
            pend <= '0; sie <= '0; prio <= PR_ROTATE;
            istat <= '0; imask <= '0; rot <= 1'b0;
            owner <= 3'h0; busy <= 1'b0; irq_d <= '0;
            mem_req_o <= 1'b0; mem_we_o <= 1'b0;
            mem_adr_o <= '0; mem_wdat_o <= '0; cpu_gnt_o <= 1'b0;
        end else begin
            irq_d     <= irq_s;
            cpu_gnt_o <= cpu_req_i && !dma_win && !busy;
            // Memory cycle completion
            // halt waits for cycle boundary
            if (busy && mem_rdy_i) begin
                busy      <= 1'b0;
                mem_req_o <= 1'b0;
                if (st[owner] == SDC_READ) begin
                    dbuf[owner] <= mem_rdat_i;
                    src[owner]  <= src[owner] + AW'(1);
                    st[owner]   <= SDC_WRITE;
                end else begin
                    dst[owner] <= dst[owner] + AW'(1);
                    cnt[owner] <= cnt[owner] - 16'h1;
                    st[owner]  <= SDC_READ;
                    if (cnt[owner] == 16'h1) begin
                        ctrl[owner][START_LSB+:2] <= ST_DONE;
                        st[owner]                 <= SDC_IDLE;
                    end
                end
            end else if (dma_win) begin
                busy      <= 1'b1;
                owner     <= pick;
                mem_req_o <= 1'b1;
                mem_we_o  <= (st[pick] == SDC_WRITE);
                mem_adr_o <= (st[pick] == SDC_WRITE) ? dst[pick] : src[pick];
                mem_wdat_o <= dbuf[pick];
                // Consume the sync event on the side that waited for it
                if (st[pick] == SDC_READ ? rd_need[pick] : wr_need[pick]) pend[pick] <= 1'b0;
            end
            if (pick_v && cpu_req_i && !busy) rot <= !rot;
            // Interrupt latch per channel
            for (int i = 0; i < NCH; i++) begin
                if (irq_s[i] && !irq_d[i]) pend[i] <= 1'b1;
                if (ctrl[i][START_LSB+:2] == ST_RUN && st[i] == SDC_IDLE) st[i] <= SDC_READ;
                // Stopped half parks once no cycle of its own is in flight
                if (ctrl[i][START_LSB+:2] != ST_RUN && !(busy && owner == 3'(i))) st[i] <= SDC_IDLE;
                ctrl[i][STAT_LSB+:2]  <= (ctrl[i][START_LSB+:2] == ST_HALT_RD &&
                                          !(busy && owner == 3'(i))) ? 2'h1 : 2'h0;
                ctrl[i][ASTAT_LSB+:2] <= (ctrl[i][ASTART_LSB+:2] == ST_HALT_RD) ? 2'h1 : 2'h0;
                if (done_ev[i]) istat[i] <= 1'b1;
            end
            // Software writes
            if (wr) begin
                if (wb_adr_i < OFF_SIE) begin
                    if (wb_adr_i[4:0] == OFF_CTRL[4:0]) begin
                        ctrl[ch_a][23:0] <= wb_dat_i[23:0];
                        ctrl[ch_a][SAME_PORT_B] <= wb_dat_i[SAME_PORT_B];
                        if (wb_dat_i[START_LSB+:2] == ST_RESET) begin
                            pend[ch_a] <= 1'b0;
                            if (!done_ev[ch_a]) istat[ch_a] <= 1'b0;
                        end
                        if (wb_dat_i[START_LSB+:2] != ST_RUN && !(busy && owner == ch_a)) begin
                            st[ch_a] <= SDC_IDLE;
                        end
                    end else if (wb_adr_i[4:0] == OFF_SRC[4:0]) src[ch_a] <= AW'(wb_dat_i);
                    else if (wb_adr_i[4:0] == OFF_DST[4:0])  dst[ch_a] <= AW'(wb_dat_i);
                    else if (wb_adr_i[4:0] == OFF_CNT[4:0])  cnt[ch_a] <= wb_dat_i[15:0];
                    else if (wb_adr_i[4:0] == OFF_ACNT[4:0]) acnt[ch_a] <= wb_dat_i[15:0];
                end else if (wb_adr_i == OFF_SIE) sie <= wb_dat_i[NCH-1:0];
                else if (wb_adr_i == OFF_PRIO) prio <= wb_dat_i[1:0];
                else if (wb_adr_i == OFF_IRQ_MASK) imask <= wb_dat_i[NCH-1:0];
                else if (wb_adr_i == OFF_IRQ_STAT)
                    istat <= (istat & ~wb_dat_i[NCH-1:0]) | done_ev;
            end
        end
    end
    // empty/full port stalls via mem_rdy_i
    // ============================================================
    // Read mux and acknowledge
    always_comb begin
        rdat   = 32'h0;
        rd_hit = 1'b1;
        if (wb_adr_i < OFF_SIE) begin
            if (wb_adr_i[4:0] == OFF_CTRL[4:0]) rdat = ctrl[ch_a];
            else if (wb_adr_i[4:0] == OFF_SRC[4:0]) rdat = 32'(src[ch_a]);
            else if (wb_adr_i[4:0] == OFF_DST[4:0]) rdat = 32'(dst[ch_a]);
            else if (wb_adr_i[4:0] == OFF_CNT[4:0]) rdat = {16'h0, cnt[ch_a]};
            else if (wb_adr_i[4:0] == OFF_ACNT[4:0]) rdat = {16'h0, acnt[ch_a]};
        end else if (wb_adr_i == OFF_SIE) rdat = 32'(sie);
        else if (wb_adr_i == OFF_PRIO) rdat = {30'h0, prio};
        else if (wb_adr_i == OFF_IRQ_STAT) rdat = 32'(istat);
        else if (wb_adr_i == OFF_IRQ_MASK) rdat = 32'(imask);
        else rd_hit = 1'b0;
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack      <= 1'b0;
            wb_dat_o <= 32'h0;
            irq_o    <= 1'b0;
        end else begin
            ack      <= wb_cyc_i && wb_stb_i && !ack;
            wb_dat_o <= rd_hit ? rdat : 32'h0;
            irq_o    <= |(istat & imask);
        end
    end
    assign wb_ack_o = ack;
    // ============================================================
    // Assertions
    property p_ack_one;
        @(posedge mclk_i) disable iff (!nrst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");
    property p_no_both;
        @(posedge mclk_i) disable iff (!nrst_i) !(cpu_gnt_o && mem_req_o);
    endproperty
    a_no_both: assert property (p_no_both) else $error("double grant");
    property p_irq;
        @(posedge mclk_i) disable iff (!nrst_i) (|(istat & imask)) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_irq_low;
        @(posedge mclk_i) disable iff (!nrst_i) !(|(istat & imask)) |=> !irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without status");
    property p_req_hold;
        @(posedge mclk_i) disable iff (!nrst_i) (mem_req_o && !mem_rdy_i) |=> (mem_req_o && $stable(mem_adr_o));
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("cycle dropped early");
    property p_done_code;
        @(posedge mclk_i) disable iff (!nrst_i) done_ev[0] |=> (ctrl[0][START_LSB+:2] == ST_DONE);
    endproperty
    a_done_code: assert property (p_done_code) else $error("done code missing");
    c_done: cover property (@(posedge mclk_i) |done_ev);
    c_cpu:  cover property (@(posedge mclk_i) cpu_gnt_o);
    c_irq:  cover property (@(posedge mclk_i) irq_o);
endmodule

// >>> sdc_pkg.sv
// Summary of operation
// - Six channels, any address to any address
// - Control reset write clears latched interrupts
// - Selectable CPU/channel priority, rotating option included
// - Channel losing arbitration stays ungranted, may stall
// - Interrupt-synced channel moves only on interrupt
// - Empty/full port FIFO access stalls bus
// - Port-to-port uses only one sync kind
// - Halt code stops one half only
// - Halt at read/write boundary after cycle
// - Status field shows half actually halted
// - Start field bits 22-23, CPU may stop
// - Sync field bits 6-7 plus enable bits
// - Finished block reads start field 10
// ============================================================
// Package of shared constants
package sdc_pkg;
    // Channel count and register stride
    localparam int          NCH          = 6;
    localparam logic [7:0]  CH_STRIDE    = 8'h08;
    // Per-channel register offsets (byte addresses, stride 8 words)
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_SRC      = 8'h04;
    localparam logic [7:0]  OFF_DST      = 8'h08;
    localparam logic [7:0]  OFF_CNT      = 8'h0c;
    localparam logic [7:0]  OFF_ACNT     = 8'h10;
    // Global registers
    localparam logic [7:0]  OFF_SIE      = 8'hc0;
    localparam logic [7:0]  OFF_PRIO     = 8'hc4;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'hc8;
    localparam logic [7:0]  OFF_IRQ_MASK = 8'hcc;
    // Control fields
    localparam int          SYNC_LSB     = 6;
    localparam int          ASTART_LSB   = 20;
    localparam int          START_LSB    = 22;
    localparam int          STAT_LSB     = 24;
    localparam int          ASTAT_LSB    = 26;
    localparam int          SAME_PORT_B  = 28;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    // Start codes
    localparam logic [1:0]  ST_RESET     = 2'h0;
    localparam logic [1:0]  ST_HALT_RD   = 2'h1;
    localparam logic [1:0]  ST_DONE      = 2'h2;
    localparam logic [1:0]  ST_RUN       = 2'h3;
    // Sync modes
    localparam logic [1:0]  SY_NONE      = 2'h0;
    localparam logic [1:0]  SY_SRC       = 2'h1;
    localparam logic [1:0]  SY_DST       = 2'h2;
    localparam logic [1:0]  SY_BOTH      = 2'h3;
    // Priority modes
    localparam logic [1:0]  PR_ROTATE    = 2'h0;
    localparam logic [1:0]  PR_DMA_HIGH  = 2'h1;
    localparam logic [1:0]  PR_CPU_HIGH  = 2'h2;
    // Channel half state
    typedef enum logic [1:0] {SDC_IDLE, SDC_READ, SDC_WRITE} sdc_state_t;
endpackage

// >>> sdc_mem_model.sv
// ============================================================
// Memory behind the transfer master: read data is the inverted
// address, writes are logged per address for the bench to inspect
module sdc_mem_model (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Request from the transfer master
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_adr_i,
    input  wire logic [31:0] mem_wdat_i,
    // Wait states before each answer
    input  wire logic [3:0]  slow_i,
    // Answer
    output logic             mem_rdy_o,
    output logic [31:0]      mem_rdat_o
);
    logic [31:0] wr_mem [logic [31:0]];  // Write log
    logic [3:0]  wait_cnt;               // Wait states spent so far

    // Answer after slow_i idle cycles; read bus toggles when not valid
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_rdy_o  <= 1'b0;
            mem_rdat_o <= 32'h0;
            wait_cnt   <= 4'h0;
        end else if (mem_req_i && !mem_rdy_o && wait_cnt >= slow_i) begin
            mem_rdy_o  <= 1'b1;
            mem_rdat_o <= mem_we_i ? ~mem_rdat_o : ~mem_adr_i;
            wait_cnt   <= 4'h0;
            if (mem_we_i) begin
                wr_mem[mem_adr_i] = mem_wdat_i;
            end
        end else begin
            mem_rdy_o  <= 1'b0;
            mem_rdat_o <= ~mem_rdat_o;
            wait_cnt   <= mem_req_i ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> tb.sv
// ============================================================
// Register-level bench for the six-channel transfer block
module tb;
    import sdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 0, nrst_i = 0;       // Clock and reset
    logic        wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [7:0]  wb_adr = 8'h0;
    logic [31:0] wb_dat = 32'h0, rd, wb_dat_o, mem_rdat, mem_wdat;
    logic        wb_ack_o, mem_req, mem_we, mem_rdy, cpu_gnt, irq_o;
    logic [5:0]  sync_irq = 6'h0;              // Interrupt sync sources
    logic [31:0] mem_adr;
    logic [3:0]  slow = 4'h0;                  // Memory wait states
    logic        cpu_req = 0, gnt_seen = 0;    // CPU contender, grant seen
    int          num_errors = 0, num_checks = 0;

    sdc_dma uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_irq_i(sync_irq),
        .port_input_ready_i(6'h0), .port_output_ready_i(6'h0), .cpu_req_i(cpu_req),
        .mem_rdy_i(mem_rdy), .mem_rdat_i(mem_rdat), .mem_req_o(mem_req), .mem_we_o(mem_we),
        .mem_adr_o(mem_adr), .mem_wdat_o(mem_wdat), .cpu_gnt_o(cpu_gnt), .irq_o(irq_o));
    sdc_mem_model mem (.mclk_i(mclk_i), .nrst_i(nrst_i), .mem_req_i(mem_req), .mem_we_i(mem_we),
        .mem_adr_i(mem_adr), .mem_wdat_i(mem_wdat), .slow_i(slow), .mem_rdy_o(mem_rdy),
        .mem_rdat_o(mem_rdat));

    // Remember any CPU grant
    always @(posedge mclk_i) if (cpu_gnt) gnt_seen <= 1'b1;

    // Clock generation
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // Compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) check(32'h0, 32'h1);
    endtask

    // Poll a two-bit control field until it shows the code, then compare it
    task automatic wait_field(input logic [7:0] a, input int lsb, input logic [1:0] code);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0);
            n++;
        end while (rd[lsb+:2] !== code && n < 200);
        check(32'(rd[lsb+:2]), 32'(code));
    endtask

    // Print counts and the verdict
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200us;
        num_errors++;
        summarize();
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        nrst_i <= 1'b1;
        wb(1'b0, 8'h00, 32'h0); check(rd, CTRL_RESET);
        wb(1'b0, 8'hd0, 32'h0); check(rd, 32'h0);
        check(32'(irq_o), 32'h0);
        // Channels 0 and 5 move one word each, slow memory
        slow <= 4'h3;
        cpu_req <= 1'b1;
        for (int c = 0; c < NCH; c += 5) begin
            wb(1'b1, 8'(32'h20 * c + 4), 32'h1000 + c);
            wb(1'b1, 8'(32'h20 * c + 8), 32'h2000 + c);
            wb(1'b1, 8'(32'h20 * c + 12), 32'h1);
            wb(1'b1, 8'(32'h20 * c), 32'(ST_RUN) << START_LSB);
            wait_field(8'(32'h20 * c), START_LSB, ST_DONE);
            check(mem.wr_mem[32'h2000 + c], ~(32'h1000 + c));
        end
        cpu_req <= 1'b0;
        check(32'(gnt_seen), 32'h1);
        wb(1'b0, OFF_IRQ_STAT, 32'h0); check(rd & 32'h21, 32'h21);
        wb(1'b1, OFF_IRQ_MASK, 32'h21);
        repeat (3) @(posedge mclk_i);
        check(32'(irq_o), 32'h1);
        // Control reset drops the latched event, write-one clears the other
        wb(1'b1, 8'h00, CTRL_RESET);
        wb(1'b0, OFF_IRQ_STAT, 32'h0); check(rd & 32'h1, 32'h0);
        wb(1'b1, OFF_IRQ_STAT, 32'h20);
        repeat (3) @(posedge mclk_i);
        check(32'(irq_o), 32'h0);
        // Interrupt-synced channel 1 waits for its source
        wb(1'b1, 8'h20, CTRL_RESET);
        wb(1'b1, 8'h24, 32'h3000);
        wb(1'b1, 8'h28, 32'h4000);
        wb(1'b1, 8'h2c, 32'h2);
        wb(1'b1, 8'h20, (32'(ST_RUN) << START_LSB) | (32'(SY_SRC) << SYNC_LSB));
        wb(1'b1, OFF_SIE, 32'h2);
        repeat (40) @(posedge mclk_i);
        wb(1'b0, 8'h20, 32'h0); check(32'(rd[23:22]), 32'(ST_RUN));
        wb(1'b0, 8'h2c, 32'h0); check(rd, 32'h2);
        // One sync event moves one element, then halt
        sync_irq <= 6'h2;
        repeat (4) @(posedge mclk_i);
        sync_irq <= 6'h0;
        repeat (30) @(posedge mclk_i);
        wb(1'b0, 8'h2c, 32'h0); check(rd, 32'h1);
        check(mem.wr_mem[32'h4000], ~32'h3000);
        wb(1'b1, 8'h20, (32'(ST_HALT_RD) << START_LSB) | (32'(SY_SRC) << SYNC_LSB));
        wait_field(8'h20, STAT_LSB, 2'h1);
        wb(1'b0, 8'h20, 32'h0); check(32'(rd[23:22]), 32'(ST_HALT_RD));
        summarize();
    end
endmodule
